// ===== logic/phybcs_pkg.sv
// constants and carrier types for the transceiver basic control/status bank
package phybcs_pkg;

  localparam int unsigned IDX_W = 5;
  localparam int unsigned REG_W = 16;

  // hexadecimal register indexes of the transceiver management space
  localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS  = 5'h01;
  localparam logic [4:0] IDX_IDENTITY_HIGH = 5'h02;
  localparam logic [4:0] IDX_IDENTITY_LOW  = 5'h03;
  localparam logic [4:0] IDX_NEG_ADVERT    = 5'h04;
  localparam logic [4:0] IDX_NEG_PARTNER   = 5'h05;
  localparam logic [4:0] IDX_NEG_EXPANSION = 5'h06;
  localparam logic [4:0] IDX_MODE_CTRL_STS = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] IDX_SPECIAL_IND   = 5'h1B;
  localparam logic [4:0] IDX_EVENT_SOURCE  = 5'h1D;
  localparam logic [4:0] IDX_EVENT_MASK    = 5'h1E;
  localparam logic [4:0] IDX_EXTRA_CTRL    = 5'h1F;

  // basic control field positions
  localparam int unsigned CTL_SOFT_RESET = 15;
  localparam int unsigned CTL_LOOPBACK   = 14;
  localparam int unsigned CTL_SPEED_100  = 13;
  localparam int unsigned CTL_AN_ENABLE  = 12;
  localparam int unsigned CTL_POWER_DOWN = 11;
  localparam int unsigned CTL_AN_RESTART = 9;
  localparam int unsigned CTL_FULL_DUP   = 8;
  localparam int unsigned CTL_COL_TEST   = 7;

  // basic status field positions
  localparam int unsigned STS_T4         = 15;
  localparam int unsigned STS_ABIL_HI    = 14;
  localparam int unsigned STS_ABIL_LO    = 11;
  localparam int unsigned STS_AN_DONE    = 5;
  localparam int unsigned STS_REM_FAULT  = 4;
  localparam int unsigned STS_AN_ABLE    = 3;
  localparam int unsigned STS_LINK_UP    = 2;
  localparam int unsigned STS_JABBER     = 1;
  localparam int unsigned STS_EXT_CAP    = 0;

  // reset values of control fields
  localparam logic RST_LOOPBACK   = 1'b0;
  localparam logic RST_AN_ENABLE  = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_COL_TEST   = 1'b0;
  localparam logic RST_SPEED_100  = 1'b1;
  localparam logic RST_FULL_DUP   = 1'b1;

  // fixed status bits: ability 100FD/100HD/10FD/10HD, auto-neg able, ext cap
  localparam logic [15:0] STS_FIXED = 16'h7809;
  // writable control bits; others read zero except bit 15 (reset in progress) and bit 9 (restart)
  localparam logic [15:0] CTL_RW_MASK = 16'h7980;

  // soft reset hold time, in cycles of clk
  localparam int unsigned SOFT_RESET_CYCLES = 16;
  localparam int unsigned CNT_W = 8;

  typedef enum logic [1:0] {
    PHYBCS_ST_RUN    = 2'b00,
    PHYBCS_ST_RESET  = 2'b01,
    PHYBCS_ST_SETTLE = 2'b11
  } phybcs_state_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [IDX_W-1:0] index;
    logic [REG_W-1:0] wdata;
  } phybcs_req_t;

  typedef struct packed {
    logic             valid;
    logic             hit;
    logic [REG_W-1:0] rdata;
  } phybcs_rsp_t;

  typedef struct packed {
    logic an_done;
    logic an_speed_100;
    logic an_full_dup;
    logic remote_fault;
    logic link_up;
    logic jabber;
  } phybcs_line_t;

  typedef struct packed {
    logic soft_reset;
    logic loopback;
    logic an_enable;
    logic an_restart;
    logic power_down;
    logic col_test;
    logic speed_100;
    logic full_dup;
  } phybcs_ctrl_t;

endpackage : phybcs_pkg

// ===== logic/phybcs_regs.sv
// basic control and status management registers of the 10/100 transceiver
module phybcs_regs
  import phybcs_pkg::*;
#(
  parameter int unsigned SOFT_CYCLES = SOFT_RESET_CYCLES
) (
  input  wire logic                    clk,      // 100 MHz device clock
  input  wire logic                    srst,     // synchronous reset
  input  wire phybcs_pkg::phybcs_req_t mgmt_req, // indexed access request
  output phybcs_pkg::phybcs_rsp_t      mgmt_rsp, // answer, one cycle later
  input  wire phybcs_pkg::phybcs_line_t line_sts, // transceiver core status
  output phybcs_pkg::phybcs_ctrl_t     ctrl      // control to the core
);
  import phybcs_pkg::*;

  // index decode shared by read and write paths
  function automatic logic idx_known(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_BASIC_CONTROL, IDX_BASIC_STATUS, IDX_IDENTITY_HIGH,
      IDX_IDENTITY_LOW, IDX_NEG_ADVERT, IDX_NEG_PARTNER,
      IDX_NEG_EXPANSION, IDX_MODE_CTRL_STS, IDX_SPECIAL_MODES,
      IDX_SPECIAL_IND, IDX_EVENT_SOURCE, IDX_EVENT_MASK,
      IDX_EXTRA_CTRL: idx_known = 1'b1;
      default:        idx_known = 1'b0;
    endcase
  endfunction : idx_known

  phybcs_state_t    state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             loopback_q, loopback_d;
  logic             an_en_q, an_en_d;
  logic             pdown_q, pdown_d;
  logic             col_q, col_d;
  logic             speed_q, speed_d;
  logic             dup_q, dup_d;
  logic             restart_q, restart_d;
  logic             an_done_q, an_done_d;
  logic             rfault_q, rfault_d;
  logic             link_q, link_d;
  logic             jabber_q, jabber_d;
  phybcs_rsp_t      rsp_q, rsp_d;
  phybcs_ctrl_t     ctrl_q, ctrl_d;

  logic             wr_ctl;
  logic             rd_sts;
  logic             soft_go;
  logic             in_reset;
  logic [REG_W-1:0] ctl_word;
  logic [REG_W-1:0] sts_word;

  assign wr_ctl   = mgmt_req.valid & mgmt_req.write
                  & (mgmt_req.index == IDX_BASIC_CONTROL);
  assign rd_sts   = mgmt_req.valid & ~mgmt_req.write
                  & (mgmt_req.index == IDX_BASIC_STATUS);
  assign in_reset = (state_q != PHYBCS_ST_RUN);
  assign soft_go  = wr_ctl & mgmt_req.wdata[CTL_SOFT_RESET] & ~in_reset;

  // control word as software reads it; bit 15 shows reset in progress
  always_comb begin
    ctl_word                 = '0;
    ctl_word[CTL_SOFT_RESET] = in_reset;
    ctl_word[CTL_LOOPBACK]   = loopback_q;
    ctl_word[CTL_SPEED_100]  = speed_q;
    ctl_word[CTL_AN_ENABLE]  = an_en_q;
    ctl_word[CTL_POWER_DOWN] = pdown_q;
    ctl_word[CTL_AN_RESTART] = restart_q;
    ctl_word[CTL_FULL_DUP]   = dup_q;
    ctl_word[CTL_COL_TEST]   = col_q;
  end

  // status word; latched bits are merged with the live condition
  always_comb begin
    sts_word                = STS_FIXED;
    sts_word[STS_AN_DONE]   = an_done_q;
    sts_word[STS_REM_FAULT] = rfault_q | line_sts.remote_fault;
    sts_word[STS_LINK_UP]   = link_q & line_sts.link_up;
    sts_word[STS_JABBER]    = jabber_q | line_sts.jabber;
  end

  // soft reset sequencer and control fields
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    loopback_d = loopback_q;
    an_en_d    = an_en_q;
    pdown_d    = pdown_q;
    col_d      = col_q;
    speed_d    = speed_q;
    dup_d      = dup_q;
    restart_d  = 1'b0;
    case (state_q)
      PHYBCS_ST_RUN: begin
        if (soft_go) begin
          state_d    = PHYBCS_ST_RESET;
          cnt_d      = CNT_W'(SOFT_CYCLES - 1);
          // fields go home in the same edge that raises soft_reset
          loopback_d = RST_LOOPBACK;
          an_en_d    = RST_AN_ENABLE;
          pdown_d    = RST_POWER_DOWN;
          col_d      = RST_COL_TEST;
        end else if (wr_ctl) begin
          loopback_d = mgmt_req.wdata[CTL_LOOPBACK];
          speed_d    = mgmt_req.wdata[CTL_SPEED_100];
          an_en_d    = mgmt_req.wdata[CTL_AN_ENABLE];
          pdown_d    = mgmt_req.wdata[CTL_POWER_DOWN];
          restart_d  = mgmt_req.wdata[CTL_AN_RESTART];
          dup_d      = mgmt_req.wdata[CTL_FULL_DUP];
          col_d      = mgmt_req.wdata[CTL_COL_TEST];
        end
      end
      PHYBCS_ST_RESET: begin
        // speed and duplex are kept over a soft reset; the other fields return home
        loopback_d = RST_LOOPBACK;
        an_en_d    = RST_AN_ENABLE;
        pdown_d    = RST_POWER_DOWN;
        col_d      = RST_COL_TEST;
        if (cnt_q == '0) begin
          state_d = PHYBCS_ST_SETTLE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      PHYBCS_ST_SETTLE: begin
        state_d = PHYBCS_ST_RUN;
      end
      default: begin
        state_d = PHYBCS_ST_RUN;
      end
    endcase
    // negotiation outcome becomes the forced speed and duplex
    if (an_en_q & line_sts.an_done & ~an_done_q) begin
      speed_d = line_sts.an_speed_100;
      dup_d   = line_sts.an_full_dup;
    end
  end

  // latching status bits; an event in the read cycle wins over the clear
  always_comb begin
    an_done_d = line_sts.an_done & ~pdown_q & ~in_reset;
    if (rd_sts) begin
      rfault_d = line_sts.remote_fault;
      jabber_d = line_sts.jabber;
      link_d   = line_sts.link_up;
    end else begin
      rfault_d = rfault_q | line_sts.remote_fault;
      jabber_d = jabber_q | line_sts.jabber;
      link_d   = link_q & line_sts.link_up;
    end
    if (in_reset) begin
      rfault_d = 1'b0;
      jabber_d = 1'b0;
      link_d   = 1'b0;
    end
  end

  // management answer: every request is answered the next cycle
  always_comb begin
    rsp_d       = '0;
    rsp_d.valid = mgmt_req.valid;
    rsp_d.hit   = mgmt_req.valid & idx_known(mgmt_req.index);
    if (mgmt_req.valid & ~mgmt_req.write) begin
      case (mgmt_req.index)
        IDX_BASIC_CONTROL: rsp_d.rdata = ctl_word;
        IDX_BASIC_STATUS:  rsp_d.rdata = sts_word;
        default:           rsp_d.rdata = '0;
      endcase
    end
  end

  // control outputs; speed and duplex follow negotiation when enabled
  always_comb begin
    ctrl_d            = '0;
    ctrl_d.soft_reset = (state_d == PHYBCS_ST_RESET);
    ctrl_d.loopback   = loopback_d;
    ctrl_d.an_enable  = an_en_d;
    ctrl_d.an_restart = restart_d & an_en_d;
    ctrl_d.power_down = pdown_d;
    ctrl_d.col_test   = col_d;
    ctrl_d.speed_100  = an_en_d ? line_sts.an_speed_100 : speed_d;
    ctrl_d.full_dup   = an_en_d ? line_sts.an_full_dup : dup_d;
  end

  // sequencer and control field registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= PHYBCS_ST_RUN;
      cnt_q      <= '0;
      loopback_q <= RST_LOOPBACK;
      an_en_q    <= RST_AN_ENABLE;
      pdown_q    <= RST_POWER_DOWN;
      col_q      <= RST_COL_TEST;
      speed_q    <= RST_SPEED_100;
      dup_q      <= RST_FULL_DUP;
      restart_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      loopback_q <= loopback_d;
      an_en_q    <= an_en_d;
      pdown_q    <= pdown_d;
      col_q      <= col_d;
      speed_q    <= speed_d;
      dup_q      <= dup_d;
      restart_q  <= restart_d;
    end
  end

  // latching status registers
  always_ff @(posedge clk) begin
    if (srst) begin
      an_done_q <= 1'b0;
      rfault_q  <= 1'b0;
      link_q    <= 1'b0;
      jabber_q  <= 1'b0;
    end else begin
      an_done_q <= an_done_d;
      rfault_q  <= rfault_d;
      link_q    <= link_d;
      jabber_q  <= jabber_d;
    end
  end

  // management answer register
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // control output register
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign mgmt_rsp = rsp_q;
  assign ctrl     = ctrl_q;

endmodule : phybcs_regs

// ===== test/phybcs_mac_model.sv
// host-side management access model issuing indexed register requests
module phybcs_mac_model
  import phybcs_pkg::*;
(
  input  wire logic                    clk,      // device clock
  output phybcs_pkg::phybcs_req_t      mgmt_req, // request to the bank
  input  wire phybcs_pkg::phybcs_rsp_t mgmt_rsp  // answer from the bank
);
  timeunit 1ns;
  timeprecision 1ns;

  initial mgmt_req = '0;

  // one indexed access; the bank has no memory-mapped path
  task automatic access(input logic wr, input logic [4:0] idx,
                        input logic [15:0] wd, output phybcs_rsp_t rsp);
    @(posedge clk);
    mgmt_req <= '{valid: 1'b1, write: wr, index: idx, wdata: wd};
    @(posedge clk);
    // released lines show the inverse rather than the last value
    mgmt_req <= '{valid: 1'b0, write: ~wr, index: ~idx, wdata: ~wd};
    #1;
    rsp = mgmt_rsp;
  endtask : access
endmodule : phybcs_mac_model

// ===== test/phybcs_regs_sva.sv
// concurrent checks on the basic control/status bank ports
module phybcs_regs_sva
  import phybcs_pkg::*;
#(
  parameter int unsigned SOFT_CYCLES = SOFT_RESET_CYCLES
) (
  input wire logic                     clk,      // device clock
  input wire logic                     srst,     // synchronous reset
  input wire phybcs_pkg::phybcs_req_t  mgmt_req, // indexed request
  input wire phybcs_pkg::phybcs_rsp_t  mgmt_rsp, // registered answer
  input wire phybcs_pkg::phybcs_line_t line_sts, // core status
  input wire phybcs_pkg::phybcs_ctrl_t ctrl      // control to core
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rd(logic [4:0] idx);
    mgmt_req.valid && !mgmt_req.write && mgmt_req.index == idx;
  endsequence

  chk_rsp_answer: assert property (mgmt_req.valid |=> mgmt_rsp.valid)
    else $error("no answer after request");
  chk_hit_known: assert property (mgmt_req.valid &&
      mgmt_req.index inside {[0:6], 17, 18, 27, [29:31]} |=> mgmt_rsp.hit)
    else $error("known index not hit");
  chk_status_fixed: assert property (s_rd(IDX_BASIC_STATUS) |=>
      (mgmt_rsp.rdata & 16'hFFC9) == 16'h7809)
    else $error("fixed status bits wrong");
  chk_ctrl_reserved: assert property (s_rd(IDX_BASIC_CONTROL) |=>
      (mgmt_rsp.rdata & 16'h047F) == 16'h0000)
    else $error("reserved control bits set");
  chk_restart_pulse: assert property (ctrl.an_restart |->
      ctrl.an_enable ##1 !ctrl.an_restart)
    else $error("restart pulse wrong");
  chk_soft_defaults: assert property ($rose(ctrl.soft_reset) |->
      ctrl.an_enable && !ctrl.loopback && !ctrl.power_down && !ctrl.col_test)
    else $error("soft reset defaults wrong");
  chk_an_mode: assert property (ctrl.an_enable ##1 ctrl.an_enable |->
      ctrl.speed_100 == $past(line_sts.an_speed_100) &&
      ctrl.full_dup == $past(line_sts.an_full_dup))
    else $error("mode does not follow negotiation");
  chk_jabber_latch: assert property (line_sts.jabber && !ctrl.soft_reset
      && !$past(ctrl.soft_reset) ##1 s_rd(IDX_BASIC_STATUS)
      |=> mgmt_rsp.rdata[STS_JABBER])
    else $error("jabber not latched");
  chk_link_latch: assert property (!line_sts.link_up && !ctrl.soft_reset
      ##1 s_rd(IDX_BASIC_STATUS) |=> !mgmt_rsp.rdata[STS_LINK_UP])
    else $error("link drop not latched");
endmodule : phybcs_regs_sva

bind phybcs_regs phybcs_regs_sva #(.SOFT_CYCLES(SOFT_CYCLES)) u_phybcs_regs_sva (
  .clk(clk), .srst(srst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
  .line_sts(line_sts), .ctrl(ctrl));

// ===== test/testbench.sv
// self-checking bench for the transceiver basic control/status bank
module testbench;
  import phybcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned SC = 2;
  logic         clk;
  logic         srst;
  phybcs_req_t  mgmt_req;
  phybcs_rsp_t  mgmt_rsp;
  phybcs_line_t line_sts;
  phybcs_ctrl_t ctrl;
  phybcs_rsp_t  r;
  int           errors;
  int           total_checks;

  phybcs_regs #(.SOFT_CYCLES(SC)) u_phybcs_regs (.clk(clk), .srst(srst),
    .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp), .line_sts(line_sts),
    .ctrl(ctrl));
  phybcs_mac_model u_phybcs_mac_model (.clk(clk), .mgmt_req(mgmt_req),
    .mgmt_rsp(mgmt_rsp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [4:0] idx,
                     input logic [15:0] wd);
    u_phybcs_mac_model.access(wr, idx, wd, r);
    check("rsp_valid", 16'h0001, {15'h0000, r.valid});
  endtask : acc

  task automatic t_reset();
    check("ctrl", 16'h0021, 16'(ctrl));
    acc(1'b0, IDX_BASIC_CONTROL, 16'h0000);
    check("control", 16'h3100, r.rdata);
    acc(1'b0, IDX_BASIC_STATUS, 16'h0000);
    check("status", 16'h7809, r.rdata);
  endtask : t_reset

  task automatic t_decode();
    logic h;
    for (int i = 0; i < 32; i++) begin
      h = (i <= 6) || i == 17 || i == 18 || i == 27 || i >= 29;
      acc(1'b0, 5'(i), 16'h0000);
      check("hit", {15'h0000, h}, {15'h0000, r.hit});
    end
  endtask : t_decode

  task automatic t_ctrl();
    acc(1'b1, IDX_BASIC_CONTROL, 16'h6DFF);
    check("ctrl", 16'h004F, 16'(ctrl));
    acc(1'b0, IDX_BASIC_CONTROL, 16'h0000);
    check("control", 16'h6980, r.rdata);
    acc(1'b1, IDX_BASIC_CONTROL, 16'h0000);
    check("ctrl", 16'h0000, 16'(ctrl));
    acc(1'b1, IDX_BASIC_CONTROL, 16'h1200);
    check("ctrl", 16'h0031, 16'(ctrl));
    @(posedge clk);
    #1;
    check("restart", 16'h0000, {15'h0000, ctrl.an_restart});
  endtask : t_ctrl

  task automatic t_soft();
    int n;
    n = 0;
    acc(1'b1, IDX_BASIC_CONTROL, 16'h4000);
    acc(1'b1, IDX_BASIC_CONTROL, 16'h8000);
    while (ctrl.soft_reset === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("soft_len", 16'(SC), 16'(n));
    acc(1'b0, IDX_BASIC_CONTROL, 16'h0000);
    check("control", 16'h1000, r.rdata);
  endtask : t_soft

  task automatic t_latch();
    @(posedge clk);
    line_sts <= 6'h0F;
    // events stand one cycle only; the read comes right after them
    fork
      acc(1'b0, IDX_BASIC_STATUS, 16'h0000);
      begin
        @(posedge clk);
        line_sts <= 6'h28;
      end
    join
    check("status", 16'h781B, r.rdata);
    @(posedge clk);
    line_sts <= 6'h2A;
    acc(1'b0, IDX_BASIC_STATUS, 16'h0000);
    check("status", 16'h7829, r.rdata);
    acc(1'b0, IDX_BASIC_STATUS, 16'h0000);
    check("status", 16'h782D, r.rdata);
    acc(1'b0, IDX_BASIC_CONTROL, 16'h0000);
    check("control", 16'h1100, r.rdata);
  endtask : t_latch

  // mid-run hardware reset: no field is kept, unlike the soft reset
  task automatic t_hard();
    @(posedge clk);
    srst     <= 1'b1;
    line_sts <= 6'h08;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
  endtask : t_hard

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    errors = 0;
    total_checks = 0;
    srst = 1'b1;
    line_sts = 6'h08;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_decode();
    t_ctrl();
    t_soft();
    t_latch();
    t_hard();
    conclude();
  end

  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule : testbench
